// ---- sbdg_pkg.sv ----
package sbdg_pkg;

    // ****************************************
    // Slave select codes (address bits 35..32)
    // ****************************************
    localparam logic [3:0] SEL_DEBUG     = 4'h1;
    localparam logic [3:0] SEL_SYS       = 4'h4;
    localparam logic [3:0] SEL_SYS_ALIAS = 4'h5;
    localparam logic [3:0] SEL_MSU       = 4'h6;

    // One-hot slave lanes
    localparam int NUM_SLV   = 3;
    localparam int SLV_DEBUG = 0;
    localparam int SLV_SYS   = 1;
    localparam int SLV_MSU   = 2;

    // ****************************************
    // Transfer sizes and lane strobes
    // ****************************************
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [3:0] STRB_BYTE = 4'h1;
    localparam logic [3:0] STRB_HALF = 4'h3;
    localparam logic [3:0] STRB_WORD = 4'hF;

    // ****************************************
    // Security windows
    // ****************************************
    localparam logic [35:0] DCOMM_START = 36'h100000110;
    localparam logic [35:0] DCOMM_END   = 36'h100000118;
    localparam logic [35:0] UPAGE_START = 36'h580800000;
    localparam logic [35:0] UPAGE_END   = 36'h581000000;
    localparam logic [35:0] FLIF_START  = 36'h5FFFE0000;
    localparam logic [35:0] FLIF_END    = 36'h5FFFE0400;
    localparam logic [35:0] FLASH_BASE  = 36'h580000000;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic        write;
        logic [1:0]  size;
        logic [35:0] addr;
        logic [31:0] wdata;
    } sbdg_dbg_req_t;

    typedef struct packed {
        logic        err;
        logic [31:0] rdata;
    } sbdg_dbg_rsp_t;

    typedef struct packed {
        logic        write;
        logic [1:0]  size;
        logic [3:0]  strb;
        logic [31:0] addr;
        logic [31:0] wdata;
    } sbdg_slv_req_t;

endpackage

// ---- sbdg_sync.sv ----
`timescale 1ns/100ps
// ****************************************
// Two-stage level synchroniser
// ****************************************
module sbdg_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // Levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] dout_r;
    logic [W-1:0] dout_nxt;

    // Stage one feeds stage two only
    always_comb begin
        meta_nxt = din;
        dout_nxt = meta_r;
    end

    // Register both stages
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            dout_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            dout_r <= dout_nxt;
        end
    end

    assign dout = dout_r;

endmodule

// ---- sbdg_guard.sv ----
`timescale 1ns/100ps
// Operation
// - 36-bit address; bits 35..32 pick the slave, low 32 bits go to it.
// - Transfers are byte, halfword or word; the slave honours the size.
// - Select 1 goes to debug registers, 4 to system bus, 6 to memory service.
// - Select 5 is a second mapping of the system bus.
// - System bus transfers run as ordinary bus transactions.
// - Every transfer is synchronised from debugger clock to system clock.
// - Any debugger to system clock ratio works.
// - Transfers need a running clock; clk_run_req asks for it without waking, but rises only at a take while mclk runs.
// - The debugger can measure its clock ratio to the system clock.
// - Security measures block or allow address ranges under control signals.
// - With security set, only debug comm registers and user page read pass.
// - With user protect too, flash interface and unprotected flash also pass.
module sbdg_guard
    import sbdg_pkg::*;
#(
    parameter int RATIO_W = 24
) (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rst,
    // Debugger request pins, four-phase handshake
    input  wire logic                dbg_req,
    input  wire sbdg_dbg_req_t       dbg_cmd,
    input  wire logic                dbg_meas_tgl,
    // Debugger answer
    output logic                     dbg_ack,
    output sbdg_dbg_rsp_t            dbg_rsp,
    output logic [RATIO_W-1:0]       ratio_cnt,
    // Security controls from flash configuration
    input  wire logic                sec_bit,
    input  wire logic                user_code_protect_control,
    input  wire logic [31:0]         boot_protected_size_size,
    input  wire logic [31:0]         flash_size,
    // Slave side
    output logic                     slv_valid,
    output logic [NUM_SLV-1:0]       slv_sel,
    output sbdg_slv_req_t            slv_req,
    input  wire logic                slv_ack,
    input  wire logic                slv_err,
    input  wire logic [31:0]         slv_rdata,
    // Power manager
    output logic                     clk_run_req
);

    // ****************************************
    // Pin synchronisation
    // ****************************************
    // Request, measuring toggle and command cross as one bundle
    localparam int PIN_W = 2 + $bits(sbdg_dbg_req_t);

    logic [PIN_W-1:0] pins_s;
    logic             req_s;
    logic             meas_s;
    sbdg_dbg_req_t    cmd_s;

    // Command bits are held stable by the debugger before req rises,
    // so the bundle settles no later than the request level
    sbdg_sync #(
        .W    (PIN_W)
    ) u_pin_sync (
        .mclk (mclk),
        .rst  (rst),
        .din  ({dbg_req, dbg_meas_tgl, dbg_cmd}),
        .dout (pins_s)
    );

    assign req_s  = pins_s[PIN_W-1];
    assign meas_s = pins_s[PIN_W-2];
    assign cmd_s  = pins_s[PIN_W-3:0];

    // ****************************************
    // Decode and security check
    // ****************************************
    logic [3:0]         sel_code;
    logic [NUM_SLV-1:0] sel_hot;
    logic               aligned;
    logic               allowed;
    logic [3:0]         strb;
    logic [35:0]        fl_lo;
    logic [35:0]        fl_hi;
    logic               in_dcomm;
    logic               in_upage;
    logic               in_flif;
    logic               in_flash;

    // Slave select from the top address nibble
    always_comb begin
        sel_code = cmd_s.addr[35:32];
        sel_hot  = '0;
        // Unlisted codes, zero among them, leave every lane low
        case (sel_code)
            SEL_DEBUG:     sel_hot[SLV_DEBUG] = 1'b1;
            SEL_SYS:       sel_hot[SLV_SYS]   = 1'b1;
            SEL_SYS_ALIAS: sel_hot[SLV_SYS]   = 1'b1;
            SEL_MSU:       sel_hot[SLV_MSU]   = 1'b1;
            default:       sel_hot            = '0;
        endcase
    end

    // Alignment and lane strobes; size code 3 is never legal
    always_comb begin
        aligned = 1'b0;
        strb    = '0;
        case (cmd_s.size)
            SIZE_BYTE: begin
                aligned = 1'b1;
                strb    = STRB_BYTE << cmd_s.addr[1:0];
            end
            SIZE_HALF: begin
                aligned = ~cmd_s.addr[0];
                strb    = STRB_HALF << {cmd_s.addr[1], 1'b0};
            end
            SIZE_WORD: begin
                aligned = (cmd_s.addr[1:0] == 2'h0);
                strb    = STRB_WORD;
            end
            default: begin
                aligned = 1'b0;
                strb    = '0;
            end
        endcase
    end

    // Address windows opened by the security controls
    // Only the start address is checked; window bounds are word aligned,
    // so an aligned transfer never straddles a window edge
    always_comb begin
        fl_lo    = FLASH_BASE + {4'h0, boot_protected_size_size};
        fl_hi    = FLASH_BASE + {4'h0, flash_size};
        in_dcomm = (cmd_s.addr >= DCOMM_START) && (cmd_s.addr <= DCOMM_END);
        in_upage = (cmd_s.addr >= UPAGE_START) && (cmd_s.addr < UPAGE_END);
        in_flif  = (cmd_s.addr >= FLIF_START) && (cmd_s.addr < FLIF_END);
        in_flash = (cmd_s.addr >= fl_lo) && (cmd_s.addr < fl_hi);
        if (!sec_bit) begin
            allowed = 1'b1;
        end else begin
            allowed = in_dcomm || (in_upage && !cmd_s.write);
            if (user_code_protect_control) begin
                allowed = allowed || in_flif || in_flash;
            end
        end
    end

    // ****************************************
    // Transfer sequencer
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUS  = 3'b010,
        ST_DONE = 3'b100
    } sbdg_state_t;

    sbdg_state_t        state_r;
    sbdg_state_t        state_nxt;
    logic               ack_r;
    logic               ack_nxt;
    sbdg_dbg_rsp_t      rsp_r;
    sbdg_dbg_rsp_t      rsp_nxt;
    logic               valid_r;
    logic               valid_nxt;
    logic [NUM_SLV-1:0] sel_r;
    logic [NUM_SLV-1:0] sel_nxt;
    sbdg_slv_req_t      sreq_r;
    sbdg_slv_req_t      sreq_nxt;
    logic               run_r;
    logic               run_nxt;

    // Next state: faulty transfers never reach a slave
    always_comb begin
        state_nxt = state_r;
        ack_nxt   = ack_r;
        rsp_nxt   = rsp_r;
        valid_nxt = valid_r;
        sel_nxt   = sel_r;
        sreq_nxt  = sreq_r;
        run_nxt   = run_r;
        case (state_r)
            ST_IDLE: begin
                if (req_s) begin
                    // Clock request rises with the take, holds until the handshake closes
                    run_nxt = 1'b1;
                    if (!aligned || !allowed || (sel_hot == '0)) begin
                        rsp_nxt.err   = 1'b1;
                        rsp_nxt.rdata = '0;
                        ack_nxt       = 1'b1;
                        state_nxt     = ST_DONE;
                    end else begin
                        valid_nxt      = 1'b1;
                        sel_nxt        = sel_hot;
                        sreq_nxt.write = cmd_s.write;
                        sreq_nxt.size  = cmd_s.size;
                        sreq_nxt.strb  = strb;
                        sreq_nxt.addr  = cmd_s.addr[31:0];
                        sreq_nxt.wdata = cmd_s.wdata;
                        state_nxt      = ST_BUS;
                    end
                end
            end
            ST_BUS: begin
                // Slave answer waits for a running clock
                if (slv_ack) begin
                    valid_nxt     = 1'b0;
                    sel_nxt       = '0;
                    rsp_nxt.err   = slv_err;
                    rsp_nxt.rdata = sreq_r.write ? 32'h0000_0000 : slv_rdata;
                    ack_nxt       = 1'b1;
                    state_nxt     = ST_DONE;
                end
            end
            ST_DONE: begin
                // Four-phase return makes the crossing ratio-free
                // The answer word keeps its value after ack falls
                if (!req_s) begin
                    ack_nxt   = 1'b0;
                    run_nxt   = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                ack_nxt   = 1'b0;
                valid_nxt = 1'b0;
                sel_nxt   = '0;
                run_nxt   = 1'b0;
            end
        endcase
    end

    // Register the sequencer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            ack_r   <= 1'b0;
            rsp_r   <= '0;
            valid_r <= 1'b0;
            sel_r   <= '0;
            sreq_r  <= '0;
            run_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ack_r   <= ack_nxt;
            rsp_r   <= rsp_nxt;
            valid_r <= valid_nxt;
            sel_r   <= sel_nxt;
            sreq_r  <= sreq_nxt;
            run_r   <= run_nxt;
        end
    end

    // ****************************************
    // Clock ratio measurement
    // ****************************************
    logic               meas_d_r;
    logic               meas_d_nxt;
    logic [RATIO_W-1:0] cnt_r;
    logic [RATIO_W-1:0] cnt_nxt;
    logic [RATIO_W-1:0] ratio_r;
    logic [RATIO_W-1:0] ratio_nxt;

    // System cycles between two debugger toggles; the counter saturates
    // so a stalled debugger reads as all ones rather than wrapping
    always_comb begin
        meas_d_nxt = meas_s;
        ratio_nxt  = ratio_r;
        cnt_nxt    = cnt_r;
        if (meas_s != meas_d_r) begin
            ratio_nxt = cnt_r;
            cnt_nxt   = '0;
        end else if (cnt_r != '1) begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    // Register the measurement
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meas_d_r <= 1'b0;
            cnt_r    <= '0;
            ratio_r  <= '0;
        end else begin
            meas_d_r <= meas_d_nxt;
            cnt_r    <= cnt_nxt;
            ratio_r  <= ratio_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Every output is a register: a stopped clock cannot raise clk_run_req,
    // so the power manager must also watch the debugger request pin
    assign dbg_ack     = ack_r;
    assign dbg_rsp     = rsp_r;
    assign ratio_cnt   = ratio_r;
    assign slv_valid   = valid_r;
    assign slv_sel     = sel_r;
    assign slv_req     = sreq_r;
    assign clk_run_req = run_r;

endmodule

// ---- sbdg_guard_props.sv ----
`timescale 1ns/100ps
// ****
// Bridge checker
// ****
module sbdg_guard_props
    import sbdg_pkg::*;
#(
    parameter int RATIO_W = 24
) (
    // Clock and reset
    input wire logic               mclk,
    input wire logic               rst,
    // Debugger side
    input wire logic               dbg_req,
    input wire sbdg_dbg_req_t      dbg_cmd,
    input wire logic               dbg_meas_tgl,
    input wire logic               dbg_ack,
    input wire sbdg_dbg_rsp_t      dbg_rsp,
    input wire logic [RATIO_W-1:0] ratio_cnt,
    // Security controls
    input wire logic               sec_bit,
    input wire logic               user_code_protect_control,
    input wire logic [31:0]        boot_protected_size_size,
    input wire logic [31:0]        flash_size,
    // Slave side and power
    input wire logic               slv_valid,
    input wire logic [NUM_SLV-1:0] slv_sel,
    input wire sbdg_slv_req_t      slv_req,
    input wire logic               slv_ack,
    input wire logic               slv_err,
    input wire logic [31:0]        slv_rdata,
    input wire logic               clk_run_req
);
    logic [35:0] a;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // Full debugger address, held stable for the whole transfer
    assign a = dbg_cmd.addr;

    // Expected lane for a select code
    function automatic logic [2:0] sel_of(input logic [3:0] s);
        case (s)
            SEL_DEBUG:              return 3'h1;
            SEL_SYS, SEL_SYS_ALIAS: return 3'h2;
            SEL_MSU:                return 3'h4;
            default:                return 3'h0;
        endcase
    endfunction

    // Two sync edges plus the take edge, so nothing may answer before that
    sequence s_quiet;
        (!slv_valid && !dbg_ack) [*3];
    endsequence

    AST_ROUTE: assert property (slv_valid |-> slv_sel == sel_of(a[35:32]))
        else $error("bad slave select");
    AST_ADDR: assert property (slv_valid |-> slv_req.addr == a[31:0])
        else $error("bad slave address");
    AST_SIZE: assert property (slv_valid |-> slv_req.size == dbg_cmd.size)
        else $error("size not passed");
    AST_ALIGN: assert property (slv_valid |-> slv_req.size == SIZE_BYTE
        || (slv_req.size == SIZE_HALF && !a[0]) || (slv_req.size == SIZE_WORD && a[1:0] == 2'h0))
        else $error("fault reached slave");
    AST_SEC: assert property (slv_valid && sec_bit && !user_code_protect_control |->
        (a >= DCOMM_START && a <= DCOMM_END) || (!dbg_cmd.write && a >= UPAGE_START && a < UPAGE_END))
        else $error("secured access passed");
    AST_ANSWER: assert property (slv_valid && slv_ack |=> dbg_ack && dbg_rsp.err == $past(slv_err))
        else $error("slave answer lost");
    AST_CLK: assert property (slv_valid |-> clk_run_req)
        else $error("clock request missing");
    AST_TAKE: assert property ($rose(dbg_req) |-> s_quiet ##[1:2] (slv_valid || dbg_ack))
        else $error("request take timing");
    AST_RUN: assert property (dbg_ack |-> clk_run_req)
        else $error("clock request dropped early");
    AST_IDLE_SEL: assert property (!slv_valid |-> slv_sel == '0)
        else $error("slave selected while idle");
endmodule

bind sbdg_guard sbdg_guard_props #(.RATIO_W(RATIO_W)) sbdg_guard_props_i (.mclk, .rst, .dbg_req,
    .dbg_cmd, .dbg_meas_tgl, .dbg_ack, .dbg_rsp, .ratio_cnt, .sec_bit, .user_code_protect_control, .boot_protected_size_size,
    .flash_size, .slv_valid, .slv_sel, .slv_req, .slv_ack, .slv_err, .slv_rdata, .clk_run_req);

// ---- sbdg_dbg_model.sv ----
`timescale 1ns/100ps
// ****
// Debugger bus master model
// ****
module sbdg_dbg_model
    import sbdg_pkg::*;
(
    // Clock and answer
    input  wire logic          mclk,
    input  wire logic          dbg_ack,
    input  wire sbdg_dbg_rsp_t dbg_rsp,
    // Request pins
    output logic               dbg_req,
    output sbdg_dbg_req_t      dbg_cmd,
    output logic               dbg_meas_tgl
);
    // Idle pins at time zero
    initial begin
        dbg_req = 1'h0;
        dbg_cmd = '0;
        dbg_meas_tgl = 1'h0;
    end

    // Four-phase transfer; a hang waiting for ack returns unknowns so the caller fails
    task automatic xfer(input sbdg_dbg_req_t c, output sbdg_dbg_rsp_t r);
        int n;
        n = 0;
        @(posedge mclk);
        dbg_cmd <= c;
        @(posedge mclk);
        dbg_req <= 1'h1;
        while (dbg_ack !== 1'h1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        r = (n < 300) ? dbg_rsp : 'x;
        dbg_req <= 1'h0;
        dbg_cmd <= ~c; // Released lines do not keep the old value
        n = 0;
        while (dbg_ack !== 1'h0 && n < 300) begin
            @(posedge mclk);
            n++;
        end
    endtask

    // One measuring interval of n clock edges
    task automatic meas(input int n);
        repeat (n) @(posedge mclk);
        dbg_meas_tgl <= ~dbg_meas_tgl;
    endtask
endmodule

// ---- test_service_bus_decode_guard.sv ----
`timescale 1ns/100ps
module test_service_bus_decode_guard
    import sbdg_pkg::*;
;
    logic mclk, rst, dbg_req, dbg_meas_tgl, dbg_ack, sec_bit, user_code_protect_control;
    logic slv_valid, slv_ack, slv_err, slv_bad, clk_run_req;
    logic [7:0] ratio_cnt;
    logic [31:0] boot_protected_size_size, flash_size, slv_rdata, last_addr, last_wdata;
    logic last_wr, last_run;
    logic [2:0] slv_sel, last_sel;
    logic [3:0] last_strb;
    sbdg_dbg_req_t dbg_cmd;
    sbdg_dbg_rsp_t dbg_rsp;
    sbdg_slv_req_t slv_req;
    int fails = 0, checks_done = 0, hits = 0, wt = 0, slv_dly = 0;

    sbdg_guard #(.RATIO_W(8)) sbdg_guard_i (.mclk, .rst, .dbg_req, .dbg_cmd, .dbg_meas_tgl,
        .dbg_ack, .dbg_rsp, .ratio_cnt, .sec_bit, .user_code_protect_control, .boot_protected_size_size, .flash_size,
        .slv_valid, .slv_sel, .slv_req, .slv_ack, .slv_err, .slv_rdata, .clk_run_req);
    sbdg_dbg_model sbdg_dbg_model_i (.mclk, .dbg_ack, .dbg_rsp, .dbg_req, .dbg_cmd, .dbg_meas_tgl);

    // Clock
    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end

    // Slave: answers after slv_dly cycles, scrambles idle data
    always @(posedge mclk) begin
        slv_ack <= 1'h0;
        slv_rdata <= ~slv_rdata;
        slv_err <= ~slv_err;
        if (slv_valid && !slv_ack) begin
            if (wt >= slv_dly) begin
                slv_ack <= 1'h1;
                slv_rdata <= {slv_req.addr[15:0], 16'hA5C3};
                slv_err <= slv_bad;
                wt <= 0;
                hits <= hits + 1;
                last_sel <= slv_sel;
                last_strb <= slv_req.strb;
                last_addr <= slv_req.addr;
                last_wdata <= slv_req.wdata;
                last_wr <= slv_req.write;
                last_run <= clk_run_req;
            end else begin
                wt <= wt + 1;
            end
        end
    end

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One transfer: e expects a refusal, s the slave lane otherwise
    task automatic go(input logic w, input logic [1:0] sz, input logic [35:0] a,
                      input logic e, input logic [2:0] s);
        sbdg_dbg_rsp_t r;
        int h;
        h = hits;
        sbdg_dbg_model_i.xfer({w, sz, a, 32'h1234_5678}, r);
        chk(r.err, e);
        chk(36'(hits - h), e ? 36'h0 : 36'h1);
        chk(clk_run_req, 1'h0);
        if (!e) begin
            chk(last_sel, s);
            chk(r.rdata, w ? 32'h0 : {a[15:0], 16'hA5C3});
            chk(last_wr, w);
            chk(last_run, 1'h1);
            if (w) begin
                chk(last_wdata, 32'h1234_5678);
            end
        end else begin
            chk(r.rdata, 32'h0);
        end
    endtask

    task automatic t_map();
        for (int i = 0; i < 16; i++) begin
            go(1'h0, SIZE_WORD, {4'(i), 32'h100}, !(i inside {1, 4, 5, 6}),
               (i == 1) ? 3'h1 : (i == 6) ? 3'h4 : 3'h2);
        end
    endtask

    task automatic t_align();
        go(1'h0, SIZE_HALF, 36'h400000001, 1'h1, 3'h0);
        go(1'h0, SIZE_WORD, 36'h400000002, 1'h1, 3'h0);
        go(1'h0, 2'h3, 36'h400000000, 1'h1, 3'h0);
        go(1'h1, SIZE_BYTE, 36'h400000003, 1'h0, 3'h2);
        chk(last_strb, 4'h8);
        go(1'h1, SIZE_HALF, 36'h500000006, 1'h0, 3'h2);
        chk(last_strb, 4'hC);
        chk(last_addr, 32'h6);
    endtask

    task automatic t_sec();
        sec_bit <= 1'h1;
        boot_protected_size_size <= 32'h1000;
        flash_size <= 32'h80000;
        go(1'h1, SIZE_WORD, 36'h100000110, 1'h0, 3'h1);
        go(1'h0, SIZE_WORD, 36'h10000011C, 1'h1, 3'h0);
        go(1'h0, SIZE_WORD, 36'h580800000, 1'h0, 3'h2);
        go(1'h1, SIZE_WORD, 36'h580800000, 1'h1, 3'h0);
        go(1'h0, SIZE_WORD, 36'h581000000, 1'h1, 3'h0);
        go(1'h1, SIZE_WORD, 36'h5FFFE0000, 1'h1, 3'h0);
        user_code_protect_control <= 1'h1;
        go(1'h1, SIZE_WORD, 36'h5FFFE03FC, 1'h0, 3'h2);
        go(1'h1, SIZE_WORD, 36'h5FFFE0400, 1'h1, 3'h0);
        go(1'h1, SIZE_WORD, 36'h580000FFC, 1'h1, 3'h0);
        go(1'h1, SIZE_WORD, 36'h580001000, 1'h0, 3'h2);
        go(1'h0, SIZE_WORD, 36'h580080000, 1'h1, 3'h0);
        go(1'h0, SIZE_WORD, 36'h100000118, 1'h0, 3'h1);
        sec_bit <= 1'h0;
        user_code_protect_control <= 1'h0;
    endtask

    // Slow slave, then a slave fault
    task automatic t_slow();
        sbdg_dbg_rsp_t r;
        int h;
        slv_dly = 20;
        go(1'h0, SIZE_WORD, 36'h600000040, 1'h0, 3'h4);
        slv_dly = 0;
        slv_bad = 1'h1;
        h = hits;
        sbdg_dbg_model_i.xfer({1'h1, SIZE_WORD, 36'h400000010, 32'h0}, r);
        chk(r.err, 1'h1);
        chk(36'(hits - h), 36'h1);
        slv_bad = 1'h0;
    endtask

    // Intervals of 40 and 55 edges differ by 15 counts
    task automatic t_ratio();
        logic [7:0] a;
        sbdg_dbg_model_i.meas(40);
        sbdg_dbg_model_i.meas(40);
        repeat (6) @(posedge mclk);
        a = ratio_cnt;
        sbdg_dbg_model_i.meas(49);
        repeat (6) @(posedge mclk);
        chk(ratio_cnt - a, 36'hF);
    endtask

    task automatic close_out();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog, well above the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        close_out();
    end

    // Main sequence
    initial begin
        rst = 1'h1;
        sec_bit = 1'h0;
        user_code_protect_control = 1'h0;
        boot_protected_size_size = 32'h0;
        flash_size = 32'h0;
        slv_ack = 1'h0;
        slv_err = 1'h0;
        slv_bad = 1'h0;
        slv_rdata = 32'h0;
        repeat (16) @(posedge mclk);
        rst <= 1'h0;
        repeat (2) @(posedge mclk);
        t_map();
        t_align();
        t_sec();
        t_slow();
        t_ratio();
        close_out();
    end
endmodule
